//--- ddc_pkg.sv
package ddc_pkg;

    localparam int ADDR_W = 16;
    localparam int BA_W   = 3;
    localparam int BANKS  = 8;

    // Address bit positions sampled with READ
    localparam int AP_BIT   = 10;
    localparam int CHOP_BIT = 12;
    localparam int COL_LOW  = 2;

    // Burst lengths in clock cycles (two data beats per clock)
    localparam logic [2:0] BL8_CYCLES = 3'h4;
    localparam logic [2:0] BC4_CYCLES = 3'h2;

    // Internal operation windows, in clock cycles
    localparam logic [3:0]  TRP_CYCLES    = 4'h6;
    localparam logic [7:0]  TRFC_CYCLES   = 8'h2C;
    localparam int          TZQCS_CYCLES  = 64;
    localparam int          TZQOPER_CYCLES = 256;
    localparam int          TZQINIT_CYCLES = 512;

    localparam logic [9:0]  ZQCS_COUNT   = 10'(TZQCS_CYCLES);
    localparam logic [9:0]  ZQOPER_COUNT = 10'(TZQOPER_CYCLES);
    localparam logic [9:0]  ZQINIT_COUNT = 10'(TZQINIT_CYCLES);

    localparam logic [BANKS-1:0]  BANKS_CLOSED = 8'h00;
    localparam logic [ADDR_W-1:0] ROW_RESET    = 16'h0000;

    typedef enum logic [3:0] {
        ddc_cmd_des, ddc_cmd_nop, ddc_cmd_act, ddc_cmd_read, ddc_cmd_write, ddc_cmd_pre,
        ddc_cmd_ref, ddc_cmd_zqcl, ddc_cmd_zqcs, ddc_cmd_mrs
    } ddc_cmd_t;

    typedef enum logic [3:0] {
        ddc_st_idle, ddc_st_active, ddc_st_precharging, ddc_st_refreshing,
        ddc_st_act_pd, ddc_st_pd, ddc_st_pre_pd, ddc_st_self_refresh
    } ddc_state_t;

    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BA_W-1:0]   ba;
        logic [ADDR_W-1:0] addr;
    } ddc_bus_t;

    typedef struct packed {
        logic [BA_W-1:0]   bank;
        logic [ADDR_W-1:0] row;
        logic [11:0]       column;
        logic [2:0]        start;
        logic              auto_pre;
        logic              chop;
    } ddc_read_t;

endpackage

//--- ddc_zq_engine.sv
`timescale 1ns/1ps
module ddc_zq_engine (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic start_long,
    input  wire logic start_short,
    input  wire logic init_done,
    output logic      busy,
    output logic      update
);
    logic [9:0] count;
    logic [9:0] next_count;

    // Long calibration window depends on whether initialization has finished
    assign next_count = start_long  ? (init_done ? ddc_pkg::ZQOPER_COUNT : ddc_pkg::ZQINIT_COUNT) :
                        start_short ? ddc_pkg::ZQCS_COUNT :
                        (count != 10'h000) ? 10'(count - 10'h001) : 10'h000;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count   <= 10'h000;
            busy    <= 1'b0;
            update  <= 1'b0;
        end else begin
            count   <= next_count;                       // R9 R11
            busy    <= next_count != 10'h000;
            update  <= (count == 10'h001) && !start_long && !start_short; // R9
        end
    end
endmodule

//--- ddc_cke_decode.sv
`timescale 1ns/1ps
// Operation
// R1: Stay in power-down or self refresh while CKE low; exit on rise with DES/NOP. Self refresh exit here ignores the command; CKE high alone ends it.
// R2: CKE fall with DES/NOP enters active, plain or precharge power-down by state.
// R3: Self refresh entered only by CKE fall with REFRESH from idle.
// R4: Controller issues only listed state, CKE and command combinations.
// R5: Controller holds CKE at each new level for the minimum registration edges.
// R6: ODT has no effect on CKE state transitions.
// R7: CS# high accepts no command; running operations continue.
// R8: NOP registers nothing and leaves running operations untouched.
// R9: ZQCL starts calibration and updates driver and termination at completion.
// R10: Controller waits init or operating long-calibration time after ZQCL.
// R11: ZQCS runs a short calibration finishing within 64 cycles.
// R12: ACTIVATE opens the addressed row in bank BA until PRECHARGE.
// R13: Controller precharges a bank before opening another row there.
// R14: READ takes starting column from A[2:0].
// R15: A10 high with READ precharges the row at burst end.
// R16: With on-the-fly enabled, A12 low chops to four, high gives eight.
// R17: A registered READ burst runs to completion uninterrupted.
// R18: READ decoded with CKE high twice, CS# low, RAS# high, CAS# low, WE# high.
// R19: Commands decode from CS#, RAS#, CAS#, WE#, CKE at the rising edge.
// R20: Self refresh exit needs no clock history; CKE high alone ends it.
// R21: No internal refresh runs in power-down.
module ddc_cke_decode (
    input  wire logic                          clock,
    input  wire logic                          reset_n,
    input  wire logic                          cke,
    input  wire ddc_pkg::ddc_bus_t             bus,
    input  wire logic                          odt,
    input  wire logic                          otf_enable,
    input  wire logic                          fixed_chop,
    input  wire logic                          init_done,
    output ddc_pkg::ddc_state_t                power_state,
    output logic [ddc_pkg::BANKS-1:0]          bank_open,
    output logic                               read_start,
    output ddc_pkg::ddc_read_t                 read_info,
    output logic                               burst_active,
    output logic                               self_refresh_run,
    output logic                               zq_busy,
    output logic                               zq_update
);
    ddc_pkg::ddc_state_t state;
    ddc_pkg::ddc_state_t next_state;
    logic                       cke_prev;
    logic [ddc_pkg::ADDR_W-1:0] row [ddc_pkg::BANKS];
    logic [2:0]                 burst_cnt;
    logic [3:0]                 prech_cnt;
    logic [7:0]                 ref_cnt;
    logic                       ap_pend;
    logic [ddc_pkg::BA_W-1:0]   ap_bank;

    function automatic ddc_pkg::ddc_cmd_t ddc_decode(input ddc_pkg::ddc_bus_t b);
        logic [2:0] code;
        code = {b.ras_n, b.cas_n, b.we_n};
        if (b.cs_n)
            return ddc_pkg::ddc_cmd_des;                 // R7
        unique case (code)
            3'h7: return ddc_pkg::ddc_cmd_nop;           // R8
            3'h3: return ddc_pkg::ddc_cmd_act;
            3'h5: return ddc_pkg::ddc_cmd_read;          // R18
            3'h4: return ddc_pkg::ddc_cmd_write;
            3'h2: return ddc_pkg::ddc_cmd_pre;
            3'h1: return ddc_pkg::ddc_cmd_ref;
            3'h6: return b.addr[ddc_pkg::AP_BIT] ? ddc_pkg::ddc_cmd_zqcl : ddc_pkg::ddc_cmd_zqcs;
            default: return ddc_pkg::ddc_cmd_mrs;
        endcase
    endfunction

    // Decode is purely from the sampled bus and CKE; odt is never looked at
    wire ddc_pkg::ddc_cmd_t cmd = ddc_decode(bus);                   // R19 R6
    wire quiet      = (cmd == ddc_pkg::ddc_cmd_des) || (cmd == ddc_pkg::ddc_cmd_nop);
    wire cke_hold   = cke_prev && cke;
    wire cke_fall   = cke_prev && !cke;
    wire cke_rise   = !cke_prev && cke;
    wire in_sleep   = (state == ddc_pkg::ddc_st_act_pd) || (state == ddc_pkg::ddc_st_pd) ||
                      (state == ddc_pkg::ddc_st_pre_pd) || (state == ddc_pkg::ddc_st_self_refresh);
    wire awake      = !in_sleep;
    wire is_idle    = (state == ddc_pkg::ddc_st_idle);
    wire can_bank   = is_idle || (state == ddc_pkg::ddc_st_active);
    wire reading    = burst_cnt != 3'h0;
    wire take       = awake && cke_hold;                             // R19
    wire sel_open   = bank_open[bus.ba];
    wire do_act     = take && (cmd == ddc_pkg::ddc_cmd_act) && can_bank && !sel_open;   // R12
    wire do_read    = take && (cmd == ddc_pkg::ddc_cmd_read) && sel_open && !reading;   // R18 R17
    wire do_pre     = take && (cmd == ddc_pkg::ddc_cmd_pre) && (can_bank ||
                      state == ddc_pkg::ddc_st_precharging);
    wire pre_all    = bus.addr[ddc_pkg::AP_BIT];
    wire do_ref     = take && (cmd == ddc_pkg::ddc_cmd_ref) && is_idle && !reading;
    wire do_sre     = awake && cke_fall && (cmd == ddc_pkg::ddc_cmd_ref) && is_idle
                      && !reading && !ap_pend;                       // R3
    wire do_zql     = take && (cmd == ddc_pkg::ddc_cmd_zqcl) && is_idle;                // R9
    wire do_zqs     = take && (cmd == ddc_pkg::ddc_cmd_zqcs) && is_idle;                // R11
    wire chop       = otf_enable ? !bus.addr[ddc_pkg::CHOP_BIT] : fixed_chop;           // R16
    wire burst_end  = burst_cnt == 3'h1;
    wire ap_close   = burst_end && ap_pend;                          // R15
    wire [ddc_pkg::BANKS-1:0] act_mask = do_act ? ddc_pkg::BANKS'(1) << bus.ba : ddc_pkg::BANKS_CLOSED;
    wire [ddc_pkg::BANKS-1:0] pre_mask = do_pre ? (pre_all ? ~ddc_pkg::BANKS_CLOSED :
                                          ddc_pkg::BANKS'(1) << bus.ba) : ddc_pkg::BANKS_CLOSED;
    wire [ddc_pkg::BANKS-1:0] ap_mask  = ap_close ? ddc_pkg::BANKS'(1) << ap_bank : ddc_pkg::BANKS_CLOSED;
    wire [ddc_pkg::BANKS-1:0] next_open = (bank_open | act_mask) & ~pre_mask & ~ap_mask;
    wire ddc_pkg::ddc_state_t wake_state = (next_open != ddc_pkg::BANKS_CLOSED) ? ddc_pkg::ddc_st_active :
                                 (prech_cnt > 4'h1) ? ddc_pkg::ddc_st_precharging : ddc_pkg::ddc_st_idle;
    wire [2:0] next_burst = do_read ? (chop ? ddc_pkg::BC4_CYCLES : ddc_pkg::BL8_CYCLES) :
                            reading ? 3'(burst_cnt - 3'h1) : 3'h0;   // R17
    wire [3:0] next_prech = (do_pre || ap_close) ? ddc_pkg::TRP_CYCLES :
                            (prech_cnt != 4'h0) ? 4'(prech_cnt - 4'h1) : 4'h0;
    wire [7:0] next_ref   = do_ref ? ddc_pkg::TRFC_CYCLES :
                            (ref_cnt != 8'h00) ? 8'(ref_cnt - 8'h01) : 8'h00;

    always_comb begin
        next_state = state;
        unique case (state)
            ddc_pkg::ddc_st_act_pd, ddc_pkg::ddc_st_pd, ddc_pkg::ddc_st_pre_pd: begin
                if (cke_rise && quiet)                       // R1
                    next_state = wake_state;
            end
            ddc_pkg::ddc_st_self_refresh: begin
                if (cke)                                     // R20 R1
                    next_state = ddc_pkg::ddc_st_idle;
            end
            default: begin
                if (do_sre)
                    next_state = ddc_pkg::ddc_st_self_refresh;
                else if (awake && cke_fall && quiet) begin   // R2
                    if (reading || state == ddc_pkg::ddc_st_precharging)
                        next_state = ddc_pkg::ddc_st_pd;
                    else if (state == ddc_pkg::ddc_st_active)
                        next_state = ddc_pkg::ddc_st_act_pd;
                    else
                        next_state = ddc_pkg::ddc_st_pre_pd;
                end else if (do_ref)
                    next_state = ddc_pkg::ddc_st_refreshing;
                else if (do_pre)
                    next_state = ddc_pkg::ddc_st_precharging;
                else if (state == ddc_pkg::ddc_st_refreshing && ref_cnt > 8'h01)
                    next_state = ddc_pkg::ddc_st_refreshing;
                else if (state == ddc_pkg::ddc_st_precharging && prech_cnt > 4'h1)
                    next_state = ddc_pkg::ddc_st_precharging;
                else
                    next_state = (next_open != ddc_pkg::BANKS_CLOSED) ? ddc_pkg::ddc_st_active :
                                 (next_prech > 4'h1) ? ddc_pkg::ddc_st_precharging : ddc_pkg::ddc_st_idle;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state     <= ddc_pkg::ddc_st_idle;
            cke_prev  <= 1'b0;
            bank_open <= ddc_pkg::BANKS_CLOSED;
            burst_cnt <= 3'h0;
            prech_cnt <= 4'h0;
            ref_cnt   <= 8'h00;
            ap_pend   <= 1'b0;
            ap_bank   <= '0;
        end else begin
            state     <= next_state;
            cke_prev  <= cke;
            bank_open <= next_open;                          // R12 R15
            burst_cnt <= next_burst;
            prech_cnt <= next_prech;
            ref_cnt   <= next_ref;
            ap_pend   <= do_read ? bus.addr[ddc_pkg::AP_BIT] : (burst_end ? 1'b0 : ap_pend);  // R15
            ap_bank   <= do_read ? bus.ba : ap_bank;
        end
    end

    for (genvar g = 0; g < ddc_pkg::BANKS; g++) begin : g_row
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n)
                row[g] <= ddc_pkg::ROW_RESET;
            else if (do_act && bus.ba == ddc_pkg::BA_W'(g))
                row[g] <= bus.addr;                          // R12
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            power_state      <= ddc_pkg::ddc_st_idle;
            read_start       <= 1'b0;
            read_info        <= '0;
            burst_active     <= 1'b0;
            self_refresh_run <= 1'b0;
        end else begin
            power_state      <= next_state;
            read_start       <= do_read;
            burst_active     <= next_burst != 3'h0;
            self_refresh_run <= next_state == ddc_pkg::ddc_st_self_refresh;   // R21
            if (do_read) begin
                read_info.bank     <= bus.ba;
                read_info.row      <= row[bus.ba];
                read_info.column   <= {bus.addr[11], bus.addr[9:0], 1'b0} >> 1;
                read_info.start    <= bus.addr[ddc_pkg::COL_LOW:0];             // R14
                read_info.auto_pre <= bus.addr[ddc_pkg::AP_BIT];
                read_info.chop     <= chop;                                      // R16
            end
        end
    end

    ddc_zq_engine u_zq (
        .clock       (clock),
        .reset_n     (reset_n),
        .start_long  (do_zql),
        .start_short (do_zqs),
        .init_done   (init_done),
        .busy        (zq_busy),
        .update      (zq_update)
    );

    property p_hold_sleep;
        @(posedge clock) disable iff (!reset_n)
        (in_sleep && state != ddc_pkg::ddc_st_self_refresh && !cke) |=> in_sleep;
    endproperty
    a_hold_sleep: assert property (p_hold_sleep) else $error("left power-down with cke low"); // R1

    property p_pd_entry_act;
        @(posedge clock) disable iff (!reset_n)
        (state == ddc_pkg::ddc_st_active && !reading && cke_fall && quiet) |=>
            power_state == ddc_pkg::ddc_st_act_pd;
    endproperty
    a_pd_entry_act: assert property (p_pd_entry_act) else $error("no active power-down entry"); // R2

    property p_sre_only_idle;
        @(posedge clock) disable iff (!reset_n)
        $rose(self_refresh_run) |-> $past(is_idle) && !$past(cke) && $past(cke_prev);
    endproperty
    a_sre_only_idle: assert property (p_sre_only_idle) else $error("bad self refresh entry"); // R3

    property p_des_quiet;
        @(posedge clock) disable iff (!reset_n)
        bus.cs_n |=> !read_start && (bank_open == ($past(bank_open) & ~$past(ap_mask)));
    endproperty
    a_des_quiet: assert property (p_des_quiet) else $error("deselect registered a command"); // R7

    sequence s_zqcs_go;
        do_zqs ##1 zq_busy;
    endsequence
    property p_zqcs_window;
        @(posedge clock) disable iff (!reset_n)
        s_zqcs_go |-> ##[1:64] zq_update;
    endproperty
    a_zqcs_window: assert property (p_zqcs_window) else $error("short calibration too long"); // R11

    property p_act_opens;
        @(posedge clock) disable iff (!reset_n)
        do_act |=> bank_open[$past(bus.ba)] && row[$past(bus.ba)] == $past(bus.addr);
    endproperty
    a_act_opens: assert property (p_act_opens) else $error("activate did not open row"); // R12

    property p_read_column;
        @(posedge clock) disable iff (!reset_n)
        do_read |=> read_start && read_info.start == $past(bus.addr[2:0]) &&
                    read_info.chop == $past(chop);
    endproperty
    a_read_column: assert property (p_read_column) else $error("read fields wrong"); // R14

    sequence s_ap_read;
        do_read && bus.addr[ddc_pkg::AP_BIT] && !chop;
    endsequence
    property p_ap_close;
        @(posedge clock) disable iff (!reset_n)
        s_ap_read |-> ##5 !bank_open[ap_bank];
    endproperty
    a_ap_close: assert property (p_ap_close) else $error("auto precharge missed"); // R15

    property p_burst_runs;
        @(posedge clock) disable iff (!reset_n)
        (do_read && !chop) |=> burst_active [*4];
    endproperty
    a_burst_runs: assert property (p_burst_runs) else $error("burst cut short"); // R17

    property p_no_refresh_pd;
        @(posedge clock) disable iff (!reset_n)
        (state == ddc_pkg::ddc_st_pd || state == ddc_pkg::ddc_st_act_pd ||
         state == ddc_pkg::ddc_st_pre_pd) |-> !self_refresh_run && !$rose(ref_cnt != 8'h00);
    endproperty
    a_no_refresh_pd: assert property (p_no_refresh_pd) else $error("refresh in power-down"); // R21
endmodule

//--- ddc_ctl_model.sv
`timescale 1ns/1ps
module ddc_ctl_model #(
    parameter int CKE_MIN = 3
) (
    input  wire logic         clock,
    output logic              cke,
    output ddc_pkg::ddc_bus_t bus
);
    int   held;
    logic cke_q;

    initial begin
        cke   = 1'b1;
        cke_q = 1'b1;
        held  = 0;
        bus   = '1;
    end

    // Edges registered at the present level since the last change
    always @(posedge clock) begin
        held  <= (cke === cke_q) ? held + 1 : 1;
        cke_q <= cke;
    end

    // One command per call, only the listed command encodings are sent
    task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a, input logic ck);
        @(negedge clock);
        if (ck !== cke) begin
            while (held < CKE_MIN) @(negedge clock);
        end
        cke <= ck;
        bus <= '{cs_n: c[3], ras_n: c[2], cas_n: c[1], we_n: c[0], ba: b, addr: a};
        @(negedge clock);
        // Deselected: other lines no longer carry the last value
        bus <= '{cs_n: 1'b1, ras_n: ~c[2], cas_n: ~c[1], we_n: ~c[0], ba: ~b, addr: ~a};
    endtask
endmodule

//--- ddr3_cke_state_and_command_decode_test.sv
`timescale 1ns/1ps
module ddr3_cke_state_and_command_decode_test;
    logic                      clock, reset_n, cke, odt, otf_enable, fixed_chop, init_done;
    ddc_pkg::ddc_bus_t         bus;
    ddc_pkg::ddc_state_t       power_state;
    logic [ddc_pkg::BANKS-1:0] bank_open;
    logic                      read_start, burst_active, self_refresh_run, zq_busy, zq_update;
    ddc_pkg::ddc_read_t        read_info;
    int                        errors, total_checks, n;

    localparam logic [3:0] C_DES = 4'hF;
    localparam logic [3:0] C_NOP = 4'h7;
    localparam logic [3:0] C_ACT = 4'h3;
    localparam logic [3:0] C_RD  = 4'h5;
    localparam logic [3:0] C_PRE = 4'h2;
    localparam logic [3:0] C_REF = 4'h1;
    localparam logic [3:0] C_ZQ  = 4'h6;

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    ddc_ctl_model ctl (.clock(clock), .cke(cke), .bus(bus));

    ddc_cke_decode dut (
        .clock(clock), .reset_n(reset_n), .cke(cke), .bus(bus), .odt(odt), .otf_enable(otf_enable),
        .fixed_chop(fixed_chop), .init_done(init_done), .power_state(power_state), .bank_open(bank_open),
        .read_start(read_start), .read_info(read_info), .burst_active(burst_active),
        .self_refresh_run(self_refresh_run), .zq_busy(zq_busy), .zq_update(zq_update)
    );

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int k);
        repeat (k) @(negedge clock);
    endtask

    // Calibration window, optionally with NOP and deselected traffic while busy
    task automatic zq_run(input logic long, input int exp, input logic noise);
        int k;
        ctl.issue(C_ZQ, 3'h0, long ? 16'h0400 : 16'h0000, 1'b1);
        k = 0;
        if (noise) begin
            ctl.issue(C_NOP, 3'h2, 16'h0055, 1'b1);
            ctl.issue(C_ACT | 4'h8, 3'h5, 16'h0123, 1'b1);
            k = 4;
        end
        cycles(2);
        k += 2;
        check_val(zq_busy, 1'b1);
        while (zq_update !== 1'b1 && k < 700) begin
            @(negedge clock);
            k++;
        end
        if (k >= 700) begin
            errors++;
            report_and_stop();
        end
        check_val(k >= exp - 1 && k <= exp + 1, 1'b1);
        cycles(2);
        check_val(zq_busy, 1'b0);
        check_val(bank_open, 8'h00);
    endtask

    // Returns the number of cycles the burst stayed active
    task automatic do_read(input logic [15:0] a, input logic [2:0] b, output int len);
        len = 0;
        ctl.issue(C_RD, b, a, 1'b1);
        while (read_start !== 1'b1 && len < 3) begin
            @(negedge clock);
            len++;
        end
        check_val(read_start, 1'b1);
        len = 0;
        while (burst_active === 1'b1 && len < 12) begin
            @(negedge clock);
            len++;
        end
    endtask

    task automatic t_zq();
        zq_run(1'b1, 512, 1'b0);
        init_done = 1'b1;
        zq_run(1'b0, 64, 1'b0);
        zq_run(1'b1, 256, 1'b0);
        zq_run(1'b0, 64, 1'b1);
        $display("test zq done");
    endtask

    task automatic t_read();
        ctl.issue(C_ACT, 3'h3, 16'h1A5C, 1'b1);
        cycles(1);
        check_val(bank_open, 8'h08);
        check_val(power_state, ddc_pkg::ddc_st_active);
        do_read(16'h1205, 3'h3, n);
        check_val(n, 4);
        check_val(read_info.row, 16'h1A5C);
        check_val(read_info.start, 3'h5);
        check_val(read_info.column, 12'h205);
        check_val({read_info.bank, read_info.auto_pre, read_info.chop}, {3'h3, 2'b00});
        check_val(bank_open, 8'h08);
        do_read(16'h0407, 3'h3, n);
        check_val(n, 2);
        check_val({read_info.start, read_info.auto_pre, read_info.chop}, {3'h7, 2'b11});
        check_val(bank_open, 8'h00);
        cycles(10);
        check_val(power_state, ddc_pkg::ddc_st_idle);
        // Full burst with auto precharge, A11 carried into the column
        ctl.issue(C_ACT, 3'h3, 16'h0321, 1'b1);
        do_read(16'h1C02, 3'h3, n);
        check_val(n, 4);
        check_val({read_info.row, read_info.start}, {16'h0321, 3'h2});
        check_val(read_info.column, 12'h402);
        check_val(bank_open, 8'h00);
        cycles(10);
        check_val(power_state, ddc_pkg::ddc_st_idle);
        $display("test read done");
    endtask

    task automatic t_pd();
        odt = 1'b1;
        ctl.issue(C_NOP, 3'h0, 16'h0000, 1'b0);
        cycles(4);
        check_val(power_state, ddc_pkg::ddc_st_pre_pd);
        check_val(self_refresh_run, 1'b0);
        ctl.issue(C_DES, 3'h0, 16'h0000, 1'b1);
        cycles(1);
        check_val(power_state, ddc_pkg::ddc_st_idle);
        ctl.issue(C_ACT, 3'h1, 16'h0F0F, 1'b1);
        ctl.issue(C_DES, 3'h0, 16'h0000, 1'b0);
        cycles(3);
        check_val(power_state, ddc_pkg::ddc_st_act_pd);
        ctl.issue(C_NOP, 3'h0, 16'h0000, 1'b1);
        cycles(1);
        check_val(power_state, ddc_pkg::ddc_st_active);
        check_val(bank_open, 8'h02);
        otf_enable = 1'b0;
        fixed_chop = 1'b1;
        do_read(16'h1000, 3'h1, n);
        check_val(n, 2);
        otf_enable = 1'b1;
        fixed_chop = 1'b0;
        odt = 1'b0;
        // Close every bank before any later row opening
        ctl.issue(C_PRE, 3'h0, 16'h0400, 1'b1);
        cycles(8);
        check_val(bank_open, 8'h00);
        $display("test power down done");
    endtask

    task automatic t_sr();
        ctl.issue(C_REF, 3'h0, 16'h0000, 1'b0);
        cycles(4);
        check_val(power_state, ddc_pkg::ddc_st_self_refresh);
        check_val(self_refresh_run, 1'b1);
        ctl.issue(C_DES, 3'h0, 16'h0000, 1'b1);
        cycles(1);
        check_val(power_state, ddc_pkg::ddc_st_idle);
        check_val(self_refresh_run, 1'b0);
        $display("test self refresh done");
    endtask

    initial begin
        errors = 0;
        total_checks = 0;
        reset_n = 1'b0;
        odt = 1'b0;
        otf_enable = 1'b1;
        fixed_chop = 1'b0;
        init_done = 1'b0;
        repeat (20) @(negedge clock);
        check_val(bank_open, 8'h00);
        reset_n = 1'b1;
        cycles(3);
        t_zq();
        t_read();
        t_pd();
        t_sr();
        report_and_stop();
    end
endmodule
